// ---- core/plg_pkg.sv ----
/*
 plg_pkg: constants, modes and carriers for the logic cell group.
 Assumes all fabric inputs are synchronous to sys_clk.
*/
`default_nettype none
package plg_pkg;
    localparam int NUM_SLICES     = 4;
    localparam int RAM_TABLES     = 4;  // two lut tables in each of slices 0, 1
    localparam int RAM_CTRL_SLICE = 2;
    localparam logic [15:0] RAM_RESET     = 16'h0000;
    localparam logic [1:0]  Q_RESET       = 2'h0;
    localparam logic        CLK_LVL_RESET = 1'h1;
    localparam logic        CARRY_RESET   = 1'h0;

    typedef enum logic [3:0] {
        PLG_LOGIC  = 4'h1,
        PLG_RIPPLE = 4'h2,
        PLG_RAM    = 4'h4,
        PLG_ROM    = 4'h8
    } plg_mode_t;

    typedef struct packed {
        logic [3:0] lut0;
        logic [3:0] lut1;
        logic [1:0] m;
        logic       ce;
        logic       local_set_reset;
        logic       clk;
    } plg_slice_in_t;

    typedef struct packed {
        plg_mode_t   mode;
        logic [15:0] init0;
        logic [15:0] init1;
        logic        neg_clk;
        logic        latch;
        logic        sr_async;
        logic        sr_val;
    } plg_slice_cfg_t;

    typedef struct packed {
        logic [1:0] f;
        logic [1:0] q;
        logic       wide_mux_out_lo;
        logic       wide_mux_out_hi;
        logic       carry_output;
    } plg_slice_out_t;

    function automatic logic plg_lut4(input logic [15:0] tbl,
                                      input logic [3:0]  idx);
        return tbl[idx];
    endfunction
endpackage
`default_nettype wire

// ---- core/plg_slice.sv ----
/*
 plg_slice: one slice, two lut4s, carry cell, lut5 mux, two storage
 elements. Assumes tables and a selected, qualified clock come from above.
*/
`timescale 1ns/1ns
`default_nettype none
module plg_slice (
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire plg_pkg::plg_slice_in_t  din,
    input  wire plg_pkg::plg_slice_cfg_t cfg,
    input  wire logic [15:0]           tbl0,
    input  wire logic [15:0]           tbl1,
    input  wire logic                  carry_in,
    output logic [1:0]                 f,
    output logic [1:0]                 q,
    output logic                       wide_lo,
    output logic                       carry_out,
    output logic                       clk_edge
);
    logic       p0;
    logic       p1;
    logic       c1;
    logic       lvl;
    logic       open_ph;
    logic       lvl_r;
    logic       lvl_nxt;
    logic [1:0] q_r;
    logic [1:0] q_nxt;

    always_comb begin
        p0 = plg_pkg::plg_lut4(tbl0, din.lut0);
        p1 = plg_pkg::plg_lut4(tbl1, din.lut1);
        c1 = p0 ? carry_in : din.lut0[0];
        if (cfg.mode == plg_pkg::PLG_RIPPLE) begin
            f         = {p1 ^ c1, p0 ^ carry_in};
            carry_out = p1 ? c1 : din.lut1[0];
        end else begin
            f         = {p1, p0};
            carry_out = carry_in;
        end
        wide_lo  = din.m[0] ? f[1] : f[0];
        lvl      = din.clk ^ cfg.neg_clk;
        lvl_nxt  = lvl;
        clk_edge = lvl & ~lvl_r;
        open_ph  = cfg.latch ? lvl : clk_edge;
        q_nxt    = q_r;
        if (din.local_set_reset && (cfg.sr_async || open_ph)) begin
            q_nxt = {2{cfg.sr_val}};
        end else if (open_ph && din.ce) begin
            q_nxt = f;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            lvl_r <= plg_pkg::CLK_LVL_RESET;
            q_r   <= plg_pkg::Q_RESET;
        end else begin
            lvl_r <= lvl_nxt;
            q_r   <= q_nxt;
        end
    end

    assign q = q_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    a_async_sr_force: assert property (
        din.local_set_reset && cfg.sr_async |=> q == {2{$past(cfg.sr_val)}})
        else $error("async set/reset not applied");
    a_sync_sr_wait: assert property (
        din.local_set_reset && !cfg.sr_async && !open_ph |=> $stable(q))
        else $error("sync set/reset acted off the clock");
    a_hold_no_ce: assert property (
        !din.ce && !din.local_set_reset |=> $stable(q))
        else $error("storage changed without clock enable");
    a_edge_capture: assert property (
        !cfg.latch && clk_edge && din.ce && !din.local_set_reset
        |=> q == $past(f))
        else $error("edge capture missed");
    a_latch_follow: assert property (
        cfg.latch && lvl && din.ce && !din.local_set_reset ##1
        cfg.latch && lvl && din.ce && !din.local_set_reset
        |=> q == $past(f))
        else $error("open latch not transparent");
    a_lut5_select: assert property (
        din.m[0] |-> wide_lo == f[1])
        else $error("lut5 mux picked wrong table");
endmodule // plg_slice
`default_nettype wire

// ---- core/plg_logic_cell_group.sv ----
/*
 plg_logic_cell_group: four slices with carry chain, wide muxes,
 distributed ram in slices 0 and 1 run from slice 2, clock select and
 chip select. Assumes fabric inputs synchronous to sys_clk; all outputs
 are registered, q two cycles and the rest one cycle after the inputs.
*/
// What this block does
// - four slices, each two lut4s feeding two storage elements
// - only slices 0 and 1 may act as ram; slices 2 and 3 never
// - each slice selectable as logic, ripple carry or rom
// - wide muxes build five to eight input functions
// - set/reset to storage, chosen synchronous or asynchronous
// - storage as flop or latch, either clock polarity
// - thirteen routing inputs plus a carry input per slice
// - six routing outputs and one carry output per slice
// - clock select, chip select qualifier, wide ram decode
// - slice 2 supplies ram write clock and write enable
// - ram write data bits 3:2 to slice 1, 1:0 to slice 0
// - four bit ram write address from slice 2 lut inputs
`timescale 1ns/1ns
`default_nettype none
module plg_logic_cell_group (
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    input  wire plg_pkg::plg_slice_in_t  [3:0] slice_in,
    input  wire plg_pkg::plg_slice_cfg_t [3:0] slice_cfg,
    input  wire logic                         global_clk,
    input  wire logic                         clk_sel,
    input  wire logic                         cs_en,
    input  wire logic                         chip_sel,
    input  wire logic                         carry_input,
    input  wire logic                         wide_ext_in,
    output logic                              carry_output,
    output var plg_pkg::plg_slice_out_t  [3:0] slice_out
);
    plg_pkg::plg_slice_in_t [3:0]  sin;
    plg_pkg::plg_slice_out_t [3:0] out_nxt;
    plg_pkg::plg_slice_out_t [3:0] out_r;
    logic [3:0][1:0][15:0]         tbl;
    logic [3:0][1:0]               f;
    logic [3:0][1:0]               q;
    logic [3:0]                    lo;
    logic [3:0]                    hi;
    logic [3:0]                    edge_s;
    logic [4:0]                    cy;
    logic                          cs_ok;
    logic                          mem_write_enable;
    logic [3:0]                    mem_write_address;
    logic [3:0]                    mem_write_data;
    logic [15:0]                   ram_r   [0:3];
    logic [15:0]                   ram_nxt [0:3];
    logic                          carry_r;
    logic                          carry_nxt;

    // ram decode, shared by write lanes and read tables
    function automatic logic ram_mode(input plg_pkg::plg_slice_cfg_t c);
        return c.mode == plg_pkg::PLG_RAM;
    endfunction

    // clock select and chip select qualify every slice
    always_comb begin
        cs_ok = !cs_en || chip_sel;
        for (int s = 0; s < plg_pkg::NUM_SLICES; s++) begin
            sin[s]    = slice_in[s];
            sin[s].clk = clk_sel ? global_clk : slice_in[s].clk;
            sin[s].ce  = slice_in[s].ce & cs_ok;
        end
    end

    // ram controls all come from slice 2
    always_comb begin
        mem_write_enable = slice_in[plg_pkg::RAM_CTRL_SLICE].local_set_reset
                           & edge_s[plg_pkg::RAM_CTRL_SLICE] & cs_ok;
        mem_write_address = slice_in[plg_pkg::RAM_CTRL_SLICE].lut0;
        mem_write_data    = slice_in[plg_pkg::RAM_CTRL_SLICE].lut1;
    end

    // table index i: slice i/2, lut i%2; data bit i lands in table i
    always_comb begin
        for (int i = 0; i < plg_pkg::RAM_TABLES; i++) begin
            ram_nxt[i] = ram_r[i];
            if (mem_write_enable && ram_mode(slice_cfg[i >> 1])) begin
                ram_nxt[i][mem_write_address] = mem_write_data[i];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < plg_pkg::RAM_TABLES; i++) begin
                ram_r[i] <= plg_pkg::RAM_RESET;
            end
        end else begin
            for (int i = 0; i < plg_pkg::RAM_TABLES; i++) begin
                ram_r[i] <= ram_nxt[i];
            end
        end
    end

    // ram tables only for slices 0 and 1; slices 2, 3 read their init
    always_comb begin
        for (int s = 0; s < plg_pkg::NUM_SLICES; s++) begin
            tbl[s][0] = slice_cfg[s].init0;
            tbl[s][1] = slice_cfg[s].init1;
        end
        for (int s = 0; s < 2; s++) begin
            if (ram_mode(slice_cfg[s])) begin
                tbl[s][0] = ram_r[2 * s];
                tbl[s][1] = ram_r[2 * s + 1];
            end
        end
    end

    assign cy[0] = carry_input;

    generate
        for (genvar g = 0; g < plg_pkg::NUM_SLICES; g++) begin : g_slice
            plg_slice u_slice (
                .sys_clk   (sys_clk),
                .reset     (reset),
                .din       (sin[g]),
                .cfg       (slice_cfg[g]),
                .tbl0      (tbl[g][0]),
                .tbl1      (tbl[g][1]),
                .carry_in  (cy[g]),
                .f         (f[g]),
                .q         (q[g]),
                .wide_lo   (lo[g]),
                .carry_out (cy[g + 1]),
                .clk_edge  (edge_s[g])
            );
        end
    endgenerate

    // lut6 in slices 0 and 2, lut7 in slice 1, lut8 in slice 3
    always_comb begin
        hi[0] = slice_in[0].m[1] ? lo[1] : lo[0];
        hi[2] = slice_in[2].m[1] ? lo[3] : lo[2];
        hi[1] = slice_in[1].m[1] ? hi[2] : hi[0];
        hi[3] = slice_in[3].m[1] ? wide_ext_in : hi[1];
    end

    always_comb begin
        for (int s = 0; s < plg_pkg::NUM_SLICES; s++) begin
            out_nxt[s].f               = f[s];
            out_nxt[s].q               = q[s];
            out_nxt[s].wide_mux_out_lo = lo[s];
            out_nxt[s].wide_mux_out_hi = hi[s];
            out_nxt[s].carry_output    = cy[s + 1];
        end
        carry_nxt = cy[plg_pkg::NUM_SLICES];
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            out_r   <= '0;
            carry_r <= plg_pkg::CARRY_RESET;
        end else begin
            out_r   <= out_nxt;
            carry_r <= carry_nxt;
        end
    end

    assign slice_out    = out_r;
    assign carry_output = carry_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    a_ram_write_bit: assert property (
        mem_write_enable && slice_cfg[0].mode == plg_pkg::PLG_RAM
        |=> ram_r[0][$past(mem_write_address)] == $past(mem_write_data[0]))
        else $error("ram write to slice 0 lost");
    a_ram_hi_lane: assert property (
        mem_write_enable && slice_cfg[1].mode == plg_pkg::PLG_RAM
        |=> ram_r[3][$past(mem_write_address)] == $past(mem_write_data[3]))
        else $error("ram write to slice 1 lost");
    a_ram_hold_idle: assert property (
        !mem_write_enable |=> ram_r[0] == $past(ram_r[0])
                              && ram_r[2] == $past(ram_r[2]))
        else $error("ram changed without write");
    a_ram_read_path: assert property (
        slice_cfg[1].mode == plg_pkg::PLG_RAM
        |=> slice_out[1].f[0] == $past(ram_r[2][slice_in[1].lut0]))
        else $error("ram read not from table");
    a_slice3_no_ram: assert property (
        slice_cfg[3].mode == plg_pkg::PLG_RAM
        |=> slice_out[3].f[0] ==
            $past(slice_cfg[3].init0[slice_in[3].lut0]))
        else $error("slice 3 acted as ram");
    a_cs_blocks_write: assert property (
        cs_en && !chip_sel |-> !mem_write_enable ##1 $stable(ram_r[1]))
        else $error("write passed a closed chip select");
    a_lut6_mux: assert property (
        1'b1 |=> slice_out[0].wide_mux_out_hi ==
                 $past(slice_in[0].m[1] ? lo[1] : lo[0]))
        else $error("lut6 mux wrong");
    a_carry_chain: assert property (
        1'b1 |=> carry_output == $past(cy[4])
                 && slice_out[0].carry_output == $past(cy[1]))
        else $error("carry output not from chain");
    a_lut7_mux: assert property (
        1'b1 |=> slice_out[1].wide_mux_out_hi ==
                 $past(slice_in[1].m[1] ? hi[2] : hi[0]))
        else $error("lut7 mux wrong");
    a_lut8_mux: assert property (
        1'b1 |=> slice_out[3].wide_mux_out_hi ==
                 $past(slice_in[3].m[1] ? wide_ext_in : hi[1]))
        else $error("lut8 mux wrong");
    a_ram_needs_lsr: assert property (
        !slice_in[plg_pkg::RAM_CTRL_SLICE].local_set_reset
        |=> ram_r[1] == $past(ram_r[1]) && ram_r[3] == $past(ram_r[3]))
        else $error("ram written without set/reset strobe");
    a_ram_addr_lane: assert property (
        mem_write_enable && slice_cfg[0].mode == plg_pkg::PLG_RAM
        |=> ram_r[1][$past(slice_in[2].lut0)] ==
            $past(slice_in[2].lut1[1]))
        else $error("ram write address or lane wrong");
    a_cs_gates_ce: assert property (
        cs_en && !chip_sel
        |-> !(sin[0].ce || sin[1].ce || sin[2].ce || sin[3].ce))
        else $error("clock enable passed a closed chip select");
    a_clk_select: assert property (
        clk_sel |-> sin[3].clk == global_clk)
        else $error("global clock not selected");
endmodule // plg_logic_cell_group
`default_nettype wire

// ---- tb/plg_fabric_clk.sv ----
/*
 plg_fabric_clk: fabric clock source that feeds global_clk.
 Assumes run comes from the bench; the level stands low when idle.
*/
`timescale 1ns/1ns
`default_nettype none
module plg_fabric_clk (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic run,
    output logic      clk_lvl
);
    logic [1:0] cnt_r;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_r   <= 2'h0;
            clk_lvl <= 1'h0;
        end else if (run) begin
            cnt_r   <= cnt_r + 2'h1;
            clk_lvl <= cnt_r[1];
        end else begin
            cnt_r   <= 2'h0;
            clk_lvl <= 1'h0;
        end
    end
endmodule // plg_fabric_clk
`default_nettype wire

// ---- tb/tb_programmable_logic_slice.sv ----
/*
 tb_programmable_logic_slice: self-checking bench for the cell group.
 Assumes plg_pkg, the cell group and plg_fabric_clk compile first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_programmable_logic_slice;
    plg_pkg::plg_slice_in_t  [3:0] si;
    plg_pkg::plg_slice_cfg_t [3:0] sc;
    plg_pkg::plg_slice_out_t [3:0] so;
    logic        sys_clk, reset, clk_sel, cs_en, chip_sel, cin, ext, run;
    logic        cout, gclk;
    logic [31:0] lfsr_r;
    logic [15:0] rm [4];
    logic [7:0]  eq, qv, fv;
    logic [3:0]  lv, hv, cv;
    int          fails = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    plg_logic_cell_group plg_logic_cell_group_i (
        .sys_clk(sys_clk), .reset(reset), .slice_in(si), .slice_cfg(sc),
        .global_clk(gclk), .clk_sel(clk_sel), .cs_en(cs_en),
        .chip_sel(chip_sel), .carry_input(cin), .wide_ext_in(ext),
        .carry_output(cout), .slice_out(so));
    plg_fabric_clk plg_fabric_clk_i (
        .sys_clk(sys_clk), .reset(reset), .run(run), .clk_lvl(gclk));

    always_comb begin
        for (int s = 0; s < 4; s++) begin
            qv[2*s+:2] = so[s].q;
            fv[2*s+:2] = so[s].f;
            lv[s]      = so[s].wide_mux_out_lo;
            hv[s]      = so[s].wide_mux_out_hi;
            cv[s]      = so[s].carry_output;
        end
    end

    function automatic logic [31:0] rnd();
        lfsr_r = {lfsr_r[30:0], lfsr_r[31]^lfsr_r[21]^lfsr_r[1]^lfsr_r[0]};
        return lfsr_r;
    endfunction

    function automatic logic [20:0] exp_all();
        logic       c, p0, p1, c1;
        logic [7:0] f;
        logic [3:0] lo, hi, co;
        c = cin;
        for (int s = 0; s < 4; s++) begin
            p0 = sc[s].init0[si[s].lut0];
            p1 = sc[s].init1[si[s].lut1];
            if (sc[s].mode == plg_pkg::PLG_RAM && s < 2) begin
                p0 = rm[2*s][si[s].lut0];
                p1 = rm[2*s+1][si[s].lut1];
            end
            if (sc[s].mode == plg_pkg::PLG_RIPPLE) begin
                c1 = p0 ? c : si[s].lut0[0];
                f[2*s+:2] = {p1 ^ c1, p0 ^ c};
                c = p1 ? c1 : si[s].lut1[0];
            end else
                f[2*s+:2] = {p1, p0};
            lo[s] = si[s].m[0] ? f[2*s+1] : f[2*s];
            co[s] = c;
        end
        hi[0] = si[0].m[1] ? lo[1] : lo[0];
        hi[2] = si[2].m[1] ? lo[3] : lo[2];
        hi[1] = si[1].m[1] ? hi[2] : hi[0];
        hi[3] = si[3].m[1] ? ext : hi[1];
        return {co, c, hi, lo, f};
    endfunction

    task automatic chk(input string n, input logic [31:0] seen,
                       input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic rand_chk(input bit newcfg);
        logic [31:0] r;
        logic [20:0] e;
        logic [1:0]  k;
        @(posedge sys_clk);
        for (int s = 0; s < 4; s++) begin
            r = rnd();
            k = r[11] ? 2'h3 : {1'h0, r[10]};
            si[s].lut0 <= r[3:0];
            si[s].lut1 <= r[7:4];
            si[s].m    <= r[9:8];
            if (newcfg) begin
                sc[s].mode  <= plg_pkg::plg_mode_t'(4'h1 << k);
                sc[s].init0 <= r[31:16];
                sc[s].init1 <= 16'(rnd());
            end
        end
        cin <= r[12];
        ext <= r[13];
        @(posedge sys_clk);
        #1 e = exp_all();
        chk("f", fv, e[7:0]);
        chk("wide_lo", lv, e[11:8]);
        chk("wide_hi", hv, e[15:12]);
        chk("carry", cout, e[16]);
        chk("carry_chain", cv, e[20:17]);
    endtask

    task automatic pulse_clk();
        @(posedge sys_clk);
        for (int s = 0; s < 4; s++) si[s].clk <= ~sc[s].neg_clk;
        repeat (2) @(posedge sys_clk);
        for (int s = 0; s < 4; s++) si[s].clk <= sc[s].neg_clk;
    endtask

    task automatic flop_test();
        logic [31:0] r;
        logic [20:0] e;
        rand_chk(1'b1);
        r = rnd();
        @(posedge sys_clk);
        cs_en    <= r[8];
        chip_sel <= r[9];
        for (int s = 0; s < 4; s++) begin
            sc[s].neg_clk <= r[s];
            si[s].clk     <= r[s];
            sc[s].latch   <= r[s+4];
            si[s].ce      <= r[s+10];
        end
        pulse_clk();
        @(posedge sys_clk);
        #1 e = exp_all();
        for (int s = 0; s < 4; s++)
            if (r[s+10] && !(r[8] && !r[9])) eq[2*s+:2] = e[2*s+:2];
        chk("q", qv, eq);
    endtask

    task automatic sr_test();
        logic [31:0] r;
        r = rnd();
        @(posedge sys_clk);
        cs_en <= 1'h0;
        for (int s = 0; s < 4; s++) begin
            sc[s].sr_async        <= r[s];
            sc[s].sr_val          <= r[s+4];
            si[s].local_set_reset <= 1'h1;
        end
        repeat (2) @(posedge sys_clk);
        #1 for (int s = 0; s < 4; s++)
            if (r[s]) eq[2*s+:2] = {2{r[s+4]}};
        chk("q_async", qv, eq);
        pulse_clk();
        for (int s = 0; s < 4; s++) si[s].local_set_reset <= 1'h0;
        @(posedge sys_clk);
        #1 for (int s = 0; s < 4; s++) eq[2*s+:2] = {2{r[s+4]}};
        chk("q_sync", qv, eq);
    endtask

    task automatic gclk_test();
        logic [20:0] e;
        @(posedge sys_clk);
        clk_sel <= 1'h1;
        run     <= 1'h1;
        for (int s = 0; s < 4; s++) begin
            si[s].ce      <= 1'h1;
            sc[s].latch   <= 1'h0;
            sc[s].neg_clk <= 1'h0;
        end
        repeat (8) @(posedge sys_clk);
        run <= 1'h0;
        repeat (3) @(posedge sys_clk);
        #1 e = exp_all();
        eq = e[7:0];
        chk("q_global", qv, eq);
    endtask

    task automatic ram_test();
        logic [31:0] r;
        logic [3:0]  a, d;
        @(posedge sys_clk);
        clk_sel <= 1'h0;
        for (int s = 0; s < 4; s++) begin
            if (s == 2) sc[s].mode <= plg_pkg::PLG_LOGIC;
            else sc[s].mode <= plg_pkg::PLG_RAM;
            sc[s].neg_clk <= 1'h0;
            si[s].clk     <= 1'h0;
        end
        repeat (24) begin
            r = rnd();
            a = r[3:0];
            @(posedge sys_clk);
            si[2].lut0            <= a;
            si[2].lut1            <= r[7:4];
            si[2].local_set_reset <= 1'h1;
            cs_en                 <= r[8];
            chip_sel              <= r[9];
            @(posedge sys_clk);
            si[2].clk <= 1'h1;
            @(posedge sys_clk);
            si[2].clk             <= 1'h0;
            si[2].local_set_reset <= 1'h0;
            for (int s = 0; s < 2; s++) begin
                si[s].lut0 <= a;
                si[s].lut1 <= a;
            end
            if (!(r[8] && !r[9]))
                for (int t = 0; t < 4; t++) rm[t][a] = r[4+t];
            @(posedge sys_clk);
            #1 for (int t = 0; t < 4; t++) d[t] = rm[t][a];
            chk("ram", fv[3:0], d);
        end
    endtask

    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            stop_test();
        end
    end

    initial begin
        reset = 1'h1;
        si = '0;
        sc = '0;
        {clk_sel, cs_en, chip_sel, cin, ext, run} = 6'h00;
        lfsr_r = 32'h0000AA77;
        eq = {4{plg_pkg::Q_RESET}};
        for (int t = 0; t < 4; t++) rm[t] = plg_pkg::RAM_RESET;
        repeat (15) @(posedge sys_clk);
        #1 chk("reset_out", {so, cout}, 32'h00000000);
        @(posedge sys_clk);
        reset <= 1'h0;
        repeat (40) rand_chk(1'b1);
        repeat (20) flop_test();
        sr_test();
        gclk_test();
        ram_test();
        repeat (40) rand_chk(1'b0);
        stop_test();
    end
endmodule // tb_programmable_logic_slice
`default_nettype wire
